/* hdl/flash_map.svh */
/*
   Named constants of the serial flash read/program block: opcodes, lane
   widths, counts and timing. Assumes a 100 MHz system clock.
*/
`ifndef FLASH_MAP_SVH
`define FLASH_MAP_SVH

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define OP_READ 8'h03
`define OP_FAST 8'h0B
`define OP_DUAL_OUT 8'h3B
`define OP_QUAD_OUT 8'h6B
`define OP_DUAL_IO 8'hBB
`define OP_QUAD_IO 8'hEB
`define OP_WRAP_SET 8'h77
`define OP_PAGE_WRITE 8'h02
`define OP_QUAD_PAGE 8'h32
`define OP_STATUS 8'h05
`define OP_LATCH_SET 8'h06
`define OP_REPEAT_RESET 8'hFF

// ----------------------------------------
// Field values and counts
// ----------------------------------------
`define LANES_ONE 3'h1
`define LANES_DUAL 3'h2
`define LANES_QUAD 3'h4
`define ADDR_BITS 6'h18
`define ADDR_MODE_BITS 6'h20
`define BYTE_BITS 6'h08
`define DUMMY_BYTE_CLKS 4'h8
`define DUMMY_QIO_CLKS 4'h4
`define REPEAT_CODE 2'h2
`define WRAP_RESET 3'h4
`define WRAP_BASE 8'h08
`define FLASH_BYTES 21'h100000
`define MEM_AW 12
`define FIFO_DEPTH 16
`define FIFO_WIDTH 16

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_NS 10
`define T_PROG_NS 1000000
`define PROG_CYCLES_DEF (`T_PROG_NS / `CLK_NS)

`endif

/* hdl/flash_pkg.sv */
/*
   Types shared by the serial flash block. Assumes flash_map.svh for values.
*/
package flash_pkg;
   typedef logic [4:0] prot_t;  // Block-protect field
   typedef enum logic [7:0] {
      S_IDLE = 8'h01, S_CMD = 8'h02, S_ADDR = 8'h04, S_DUMMY = 8'h08,
      S_OUT = 8'h10, S_IN = 8'h20, S_WRAP = 8'h40, S_IGNORE = 8'h80
   } link_state_t;
   typedef enum logic [3:0] {
      C_IDLE = 4'h1, C_DRAIN = 4'h2, C_WRITE = 4'h4, C_TIMER = 4'h8
   } commit_state_t;
endpackage

/* hdl/pin_sync.sv */
/*
   Two-flop synchroniser bank for pins from outside the clock domain.
   Assumes the caller reads only the synced output.
*/
module pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [WIDTH-1:0] async,
   output logic [WIDTH-1:0] synced
);
   logic [WIDTH-1:0] meta;  // First stage, read only by the second

   // Both stages reset to the idle pin level
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         meta <= INIT;
         synced <= INIT;
      end else begin
         meta <= async;
         synced <= meta;
      end
   end
endmodule

/* hdl/byte_fifo.sv */
/*
   Small synchronous FIFO with valid/ready on both sides.
   Assumes DEPTH is a power of two.
*/
module byte_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] store [DEPTH];  // Word storage
   logic [AW-1:0] wrPtr;
   logic [AW-1:0] rdPtr;
   logic [AW:0] count;  // One bit wider so full is honest
   wire push = inValid & inReady;
   wire pop = outValid & outReady;

   assign inReady = (count < (AW+1)'(DEPTH));
   assign outValid = (count != '0);
   assign outData = store[rdPtr];

   // Pointers and occupancy
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else begin
         if (push) wrPtr <= wrPtr + 1'b1;
         if (pop) rdPtr <= rdPtr + 1'b1;
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   // Storage has no reset; contents are only read when valid
   always_ff @(posedge clk_sys) begin
      if (push) store[wrPtr] <= inData;
   end
endmodule

/* hdl/serial_flash.sv */
/*
   Serial NOR flash core: read family, wrap setting, page program.
   Assumes the host drives select, clock and data pins; all pins are
   sampled by clk_sys through two flops and clock edges found here.
*/
`include "flash_map.svh"

// Operation
// - Basic read: opcode, 24-bit address, data
// - Address advances by one per byte
// - Reads refused while internal cycle busy
// - Fast read adds one dummy byte
// - Dual output returns two bits per clock
// - Quad output returns four bits per clock
// - Dual I/O: address and mode on two pins
// - Dual repeat bits 10 skip next opcode
// - Quad I/O: address, mode, four dummy clocks
// - Quad repeat bits 10 skip next opcode
// - Wrap enable bit and section length codes
// - Wrapped quad read stays inside section
// - Wrap setting persists until disabled
// - Program data wraps within its page
// - Last 256 bytes kept, others untouched
// - Program only on whole byte boundary
// - Select rise starts timed busy cycle
// - Protected pages are not programmed
// - Quad program needs quad enable set
// - Status read returns busy and latch
// - Dual: odd bits pin 1, even pin 0
// - Quad address: pin 3 carries top bit
module serial_flash #(
   parameter int PROG_CYCLES = `PROG_CYCLES_DEF
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic sclkPin,
   input wire logic selectPinN,
   input wire logic [3:0] ioIn,
   output logic [3:0] ioOut,
   output logic [3:0] ioOe,
   input wire flash_pkg::prot_t protectRangeBits,
   input wire logic quadIoEnable,
   output logic busyFlag,
   output logic writeLatch
);
   import flash_pkg::*;

   // Every check below lives in the system clock domain
   default clocking cbSys @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   // ----------------------------------------
   // Pin sampling and edge detection
   // ----------------------------------------
   logic [5:0] pinSync;  // {sclk, select, io[3:0]}
   logic prevSclk;  // Last synced clock level
   logic prevSel;  // Last synced select level

   pin_sync #(.WIDTH(6), .INIT(6'h10)) uSync (
      .clk_sys(clk_sys),
      .rst(rst),
      .async({sclkPin, selectPinN, ioIn}),
      .synced(pinSync)
   );

   wire sclkS = pinSync[5];
   wire selHigh = pinSync[4];
   wire [3:0] ioS = pinSync[3:0];
   wire sclkRise = sclkS & ~prevSclk;
   wire sclkFall = ~sclkS & prevSclk;
   wire selFall = ~selHigh & prevSel;
   wire selRise = selHigh & ~prevSel;

   // Edge history
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         prevSclk <= 1'b0;
         prevSel <= 1'b1;
      end else begin
         prevSclk <= sclkS;
         prevSel <= selHigh;
      end
   end

   // ----------------------------------------
   // State and storage
   // ----------------------------------------
   link_state_t state;  // Frame sequencer
   commit_state_t commit;  // Program sequencer
   logic [7:0] opcode;  // Command of this frame
   logic [2:0] lanes;  // Pins in use per clock
   logic [5:0] bitCnt;  // Bits taken in this phase
   logic [31:0] shiftIn;  // Input shifter
   logic [3:0] dummyCnt;  // Dummy clocks left
   logic [23:0] addr;  // Current byte address
   logic [7:0] outShift;  // Output shifter
   logic [3:0] outCnt;  // Bits sent of this byte
   logic loadPending;  // Fetch next output byte
   logic repeatDual;  // Next frame is dual I/O read
   logic repeatQuad;  // Next frame is quad I/O read
   logic [2:0] wrapBits;  // {W6, W5, W4}
   logic [7:0] pageOff;  // Offset of next program byte
   logic dataSeen;  // At least one data byte
   logic pushLost;  // FIFO refused a byte
   logic latchArm;  // Latch-set command complete
   logic [`MEM_AW-9:0] progPage;  // Page being programmed
   logic [7:0] wrIdx;  // Commit walk index
   logic [31:0] progCnt;  // Program timer
   logic [7:0] mem [1 << `MEM_AW];  // Array, aliased over the map
   logic [7:0] pageBuf [256];  // Latched page data
   logic [255:0] pageMask;  // Which offsets were sent

   // ----------------------------------------
   // Decoding
   // ----------------------------------------
   // Shift in the lanes of one clock, top group first
   function automatic logic [31:0] shiftLanes(input logic [31:0] s, input logic [3:0] io,
                                              input logic [2:0] n);
      if (n == `LANES_QUAD) return {s[27:0], io};
      if (n == `LANES_DUAL) return {s[29:0], io[1:0]};
      return {s[30:0], io[0]};
   endfunction

   // Address step, folded inside the wrap section when enabled
   function automatic logic [23:0] nextAddress(input logic [23:0] a, input logic wrapOn,
                                               input logic [1:0] len);
      logic [7:0] mask;
      mask = (`WRAP_BASE << len) - 8'h01;
      if (wrapOn) return {a[23:8], (a[7:0] & ~mask) | ((a[7:0] + 8'h01) & mask)};
      return a + 24'h000001;
   endfunction

   // Top (or bottom) share of the device guarded by the protect field
   function automatic logic isProtected(input logic [23:0] a, input prot_t bp);
      logic [20:0] span;
      span = `FLASH_BYTES >> (3'h7 - bp[2:0]);
      if (bp[2:0] == 3'h0) return 1'b0;
      if (bp[4]) return {1'b0, a[19:0]} < span;
      return {1'b0, a[19:0]} >= (`FLASH_BYTES - span);
   endfunction

   wire [31:0] newShift = shiftLanes(shiftIn, ioS, lanes);
   wire [5:0] newCnt = bitCnt + {3'h0, lanes};
   wire [7:0] opSel = (state == S_CMD) ? newShift[7:0] : opcode;
   wire isDualIo = (opSel == `OP_DUAL_IO);
   wire isQuadIo = (opSel == `OP_QUAD_IO);
   wire isProg = (opSel == `OP_PAGE_WRITE) || (opSel == `OP_QUAD_PAGE);
   wire isRead = (opSel == `OP_READ) || (opSel == `OP_FAST) || (opSel == `OP_DUAL_OUT) ||
                 (opSel == `OP_QUAD_OUT) || isDualIo || isQuadIo;
   wire needsQuad = (opSel == `OP_QUAD_OUT) || isQuadIo || (opSel == `OP_QUAD_PAGE);
   wire known = isRead || isProg || (opSel == `OP_WRAP_SET) || (opSel == `OP_STATUS);
   // Only status may be read during an internal cycle
   wire refuse = (busyFlag & (opSel != `OP_STATUS)) |
                 (needsQuad & ~quadIoEnable) | ~known;
   wire [2:0] addrLanes = isQuadIo ? `LANES_QUAD : (isDualIo ? `LANES_DUAL : `LANES_ONE);
   wire [5:0] addrBits = (isQuadIo | isDualIo) ? `ADDR_MODE_BITS : `ADDR_BITS;
   wire [3:0] dummyClks = isQuadIo ? `DUMMY_QIO_CLKS :
                          ((opSel == `OP_FAST) || (opSel == `OP_DUAL_OUT) ||
                           (opSel == `OP_QUAD_OUT)) ? `DUMMY_BYTE_CLKS : 4'h0;
   wire [2:0] dataLanes = ((opSel == `OP_DUAL_OUT) | isDualIo) ? `LANES_DUAL :
                          ((opSel == `OP_QUAD_OUT) | isQuadIo |
                           (opSel == `OP_QUAD_PAGE)) ? `LANES_QUAD : `LANES_ONE;
   wire [23:0] gotAddr = (addrBits == `ADDR_MODE_BITS) ? newShift[31:8] : newShift[23:0];
   wire repeatHit = (newShift[5:4] == `REPEAT_CODE);
   wire wrapOn = (opcode == `OP_QUAD_IO) && !wrapBits[0];
   wire [7:0] statusByte = {1'b0, protectRangeBits, writeLatch, busyFlag};
   wire outByteEnd = sclkFall && !selHigh && (state == S_OUT) &&
                     (outCnt + {1'b0, lanes} == `BYTE_BITS);
   wire cmdEnd = sclkRise && !selHigh && (state == S_CMD) && (newCnt == `BYTE_BITS);
   wire inByteEnd = sclkRise && !selHigh && (state == S_IN) && (newCnt[2:0] == 3'h0);
   wire addrEnd = sclkRise && !selHigh && (state == S_ADDR) && (newCnt == addrBits);
   wire clearMask = addrEnd && isProg;

   // ----------------------------------------
   // Frame sequencer
   // ----------------------------------------
   // Inputs are taken on clock rise; select high aborts at any bit
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state <= S_IDLE;
         opcode <= 8'h00;
         lanes <= `LANES_ONE;
         bitCnt <= 6'h00;
         shiftIn <= 32'h00000000;
         dummyCnt <= 4'h0;
         addr <= 24'h000000;
         repeatDual <= 1'b0;
         repeatQuad <= 1'b0;
         wrapBits <= `WRAP_RESET;
         pageOff <= 8'h00;
         dataSeen <= 1'b0;
         latchArm <= 1'b0;
      end else if (selHigh) begin
         state <= S_IDLE;
      end else if (selFall) begin
         bitCnt <= 6'h00;
         dataSeen <= 1'b0;
         latchArm <= 1'b0;
         // A pending repeat skips the opcode phase entirely
         if (repeatDual | repeatQuad) begin
            state <= S_ADDR;
            opcode <= repeatQuad ? `OP_QUAD_IO : `OP_DUAL_IO;
            lanes <= repeatQuad ? `LANES_QUAD : `LANES_DUAL;
         end else begin
            state <= S_CMD;
            lanes <= `LANES_ONE;
         end
      end else if (sclkRise) begin
         shiftIn <= newShift;
         bitCnt <= newCnt;
         unique case (state)
            S_CMD: if (newCnt == `BYTE_BITS) begin
               opcode <= newShift[7:0];
               bitCnt <= 6'h00;
               if (newShift[7:0] == `OP_LATCH_SET) begin
                  state <= S_IGNORE;
                  latchArm <= !busyFlag;
               end else if (newShift[7:0] == `OP_REPEAT_RESET) begin
                  state <= S_IGNORE;
                  repeatDual <= 1'b0;
                  repeatQuad <= 1'b0;
               end else if (refuse) begin
                  state <= S_IGNORE;
               end else if (newShift[7:0] == `OP_STATUS) begin
                  state <= S_OUT;
               end else begin
                  state <= S_ADDR;
                  lanes <= addrLanes;
               end
            end
            S_ADDR: if (newCnt == addrBits) begin
               addr <= gotAddr;
               pageOff <= gotAddr[7:0];
               bitCnt <= 6'h00;
               dummyCnt <= dummyClks;
               if (addrBits == `ADDR_MODE_BITS) begin
                  repeatDual <= isDualIo & repeatHit;
                  repeatQuad <= isQuadIo & repeatHit;
               end
               if (opcode == `OP_WRAP_SET) begin
                  state <= S_WRAP;
               end else if (isProg) begin
                  state <= S_IN;
                  lanes <= dataLanes;
               end else begin
                  state <= (dummyClks != 4'h0) ? S_DUMMY : S_OUT;
                  lanes <= (dummyClks != 4'h0) ? lanes : dataLanes;
               end
            end
            S_DUMMY: begin
               dummyCnt <= dummyCnt - 4'h1;
               if (dummyCnt == 4'h1) begin
                  state <= S_OUT;
                  lanes <= dataLanes;
               end
            end
            S_IN: begin
               if (newCnt[2:0] == 3'h0) begin
                  pageOff <= pageOff + 8'h01;
                  dataSeen <= 1'b1;
               end
            end
            S_WRAP: if (newCnt == `BYTE_BITS) begin
               wrapBits <= newShift[6:4];
               state <= S_IGNORE;
            end
            S_OUT, S_IDLE, S_IGNORE: begin
            end
         endcase
      end else if (outByteEnd && opcode != `OP_STATUS) begin
         addr <= nextAddress(addr, wrapOn, wrapBits[2:1]);
      end
   end

   // A refused frame never turns a driver on
   a_refuse_quiet: assert property (state == S_IGNORE |-> ioOe == 4'h0)
      else $error("driver on in refused frame");
   // Quad lanes are only ever used with quad enable set
   a_quad_enable: assert property (state != S_IDLE && lanes == `LANES_QUAD |-> quadIoEnable)
      else $error("quad lanes without quad enable");
   // Linear reads step by exactly one byte
   a_addr_step: assert property (outByteEnd && !wrapOn && opcode != `OP_STATUS |=>
                                 addr == $past(addr) + 24'h000001)
      else $error("address did not step by one");
   // Wrapped reads never leave their page
   a_wrap_page: assert property (outByteEnd && wrapOn |=> addr[23:8] == $past(addr[23:8]))
      else $error("wrapped read left its page");

   // ----------------------------------------
   // Output shifter
   // ----------------------------------------
   // Data changes on clock fall; the next byte is fetched one cycle later,
   // long before the following fall at any legal link rate
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         outShift <= 8'h00;
         outCnt <= 4'h0;
         loadPending <= 1'b0;
         ioOut <= 4'h0;
         ioOe <= 4'h0;
      end else if (selHigh || state != S_OUT) begin
         ioOe <= 4'h0;
         outCnt <= 4'h0;
         loadPending <= 1'b1;
      end else if (loadPending) begin
         outShift <= (opcode == `OP_STATUS) ? statusByte : mem[addr[`MEM_AW-1:0]];
         loadPending <= 1'b0;
      end else if (sclkFall) begin
         unique case (lanes)
            `LANES_QUAD: begin
               ioOut <= outShift[7:4];
               ioOe <= 4'hF;
            end
            `LANES_DUAL: begin
               ioOut <= {2'h0, outShift[7:6]};
               ioOe <= 4'h3;
            end
            default: begin
               ioOut <= {2'h0, outShift[7], 1'b0};
               ioOe <= 4'h2;
            end
         endcase
         outShift <= outShift << lanes;
         outCnt <= outCnt + {1'b0, lanes};
         if (outByteEnd) begin
            outCnt <= 4'h0;
            loadPending <= 1'b1;
         end
      end
   end

   // Select high drops every driver on the next edge
   a_sel_release: assert property (selHigh |=> ioOe == 4'h0)
      else $error("pins still driven after select rise");

   // ----------------------------------------
   // Program path
   // ----------------------------------------
   logic fifoInReady;
   logic fifoOutValid;
   logic [15:0] fifoOut;
   wire drainReady = (commit != C_WRITE);  // Stall while the page is walked

   byte_fifo #(.WIDTH(`FIFO_WIDTH), .DEPTH(`FIFO_DEPTH)) uFifo (
      .clk_sys(clk_sys),
      .rst(rst),
      .inValid(inByteEnd),
      .inReady(fifoInReady),
      .inData({pageOff, newShift[7:0]}),
      .outValid(fifoOutValid),
      .outReady(drainReady),
      .outData(fifoOut)
   );

   // Later bytes at the same offset overwrite earlier ones
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) pageMask <= '0;
      else if (clearMask) pageMask <= '0;
      else if (fifoOutValid && drainReady) pageMask[fifoOut[15:8]] <= 1'b1;
   end
   always_ff @(posedge clk_sys) begin
      if (fifoOutValid && drainReady) pageBuf[fifoOut[15:8]] <= fifoOut[7:0];
   end

   // A refused byte spoils the frame rather than program partial data
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) pushLost <= 1'b0;
      else if (clearMask) pushLost <= 1'b0;
      else if (inByteEnd && !fifoInReady) pushLost <= 1'b1;
   end

   wire progGo = selRise && (state == S_IN) && isProg && dataSeen &&
                 (bitCnt[2:0] == 3'h0) &&
                 writeLatch &&
                 !isProtected(addr, protectRangeBits) &&
                 !busyFlag && !pushLost;

   // Commit sequencer: drain, walk 256 offsets, then timed busy
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         commit <= C_IDLE;
         busyFlag <= 1'b0;
         writeLatch <= 1'b0;
         wrIdx <= 8'h00;
         progCnt <= 32'h00000000;
         progPage <= '0;
      end else begin
         if (selRise && latchArm) writeLatch <= 1'b1;
         unique case (commit)
            C_IDLE: if (progGo) begin
               commit <= C_DRAIN;
               busyFlag <= 1'b1;
               progPage <= addr[`MEM_AW-1:8];
            end
            C_DRAIN: if (!fifoOutValid) begin
               commit <= C_WRITE;
               wrIdx <= 8'h00;
            end
            C_WRITE: begin
               wrIdx <= wrIdx + 8'h01;
               if (wrIdx == 8'hFF) begin
                  commit <= C_TIMER;
                  progCnt <= 32'h00000000;
               end
            end
            C_TIMER: begin
               progCnt <= progCnt + 32'h00000001;
               if (progCnt == 32'(PROG_CYCLES - 1)) begin
                  commit <= C_IDLE;
                  busyFlag <= 1'b0;
                  writeLatch <= 1'b0;
               end
            end
         endcase
      end
   end

   // Sent offsets take the latched byte; untouched offsets are skipped.
   // The array has no erased state, so a byte is written, not merged.
   always_ff @(posedge clk_sys) begin
      if (commit == C_WRITE && pageMask[wrIdx])
         mem[{progPage, wrIdx}] <= pageBuf[wrIdx];
   end

   // A started cycle raises busy and holds it for one more cycle
   sequence s_busyHeld;
      busyFlag ##1 busyFlag;
   endsequence
   a_busy_start: assert property (progGo |=> s_busyHeld)
      else $error("program cycle did not raise busy");
   // Only a latched write enable may start a cycle
   a_prog_latch: assert property ($rose(busyFlag) |-> $past(writeLatch))
      else $error("program started without write latch");
   // The latch is gone by the time busy clears
   a_latch_clear: assert property ($fell(busyFlag) |-> !writeLatch)
      else $error("write latch still set after cycle");
endmodule

/* sim/flash_host.sv */
/*
   Host controller model: drives select, link clock and data lanes.
   Assumes the bench merges lanes with the flash enables into pinLevel.
*/
module flash_host (
   input wire logic clk_sys,
   input wire logic [3:0] pinLevel,
   output logic sclkPin,
   output logic selectPinN,
   output logic [3:0] hostOut,
   output logic rxValid,
   output logic [7:0] rxByte
);
   timeunit 1ns;
   timeprecision 100ps;
   // Clock idles low and stands still between frames
   initial begin
      sclkPin = 1'b0;
      selectPinN = 1'b1;
      hostOut = 4'h0;
      rxValid = 1'b0;
      rxByte = 8'h00;
   end
   // One byte over n lanes; lanes not driven toggle so no stale level lingers
   task automatic xb(input logic [7:0] tx, input int n, input bit drv, input bit rcv);
      logic [7:0] rx;
      logic [3:0] mk;
      logic [3:0] v;
      rx = 8'h00;
      mk = 4'((1 << n) - 1);
      for (int k = 0; k < 8 / n; k++) begin
         v = 4'(tx >> (8 - n * (k + 1))) & mk;
         @(posedge clk_sys);
         sclkPin <= 1'b0;
         hostOut <= drv ? ((~hostOut & ~mk) | v) : ~hostOut;
         repeat (4) @(posedge clk_sys);
         sclkPin <= 1'b1;
         repeat (3) @(posedge clk_sys);
         // Sampled late in the bit, well after the output has settled
         rx = (rx << n) | 8'((n == 1) ? {3'h0, pinLevel[1]} : (pinLevel & mk));
      end
      if (rcv) begin
         rxByte <= rx;
         rxValid <= 1'b1;
         @(posedge clk_sys);
         rxValid <= 1'b0;
      end
   endtask
   task automatic frameOpen();
      @(posedge clk_sys);
      selectPinN <= 1'b0;
      repeat (4) @(posedge clk_sys);
   endtask
   // Select rises with clock high, only after a whole byte
   task automatic frameClose();
      @(posedge clk_sys);
      selectPinN <= 1'b1;
      @(posedge clk_sys);
      sclkPin <= 1'b0;
      repeat (8) @(posedge clk_sys);
   endtask
endmodule

/* sim/tb_top.sv */
/*
   Self-checking bench: the host model runs frames, a monitor compares
   each returned byte with the oldest note. Assumes a 100 MHz clk_sys.
*/
`include "flash_map.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("[FAIL] %0t: got %h, expected %h", $time, g, e); end end
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic quadIoEnable = 1'b1;
   flash_pkg::prot_t protRange = 5'h00;
   logic [3:0] ioOut, ioOe, hostOut;
   wire [3:0] pinLevel;
   logic sclkPin, selectPinN, busyFlag, writeLatch, rxValid;
   logic seenOe = 1'b0;
   logic [7:0] rxByte, e;
   logic [7:0] dat [24];
   logic [7:0] expQ [$];
   logic [31:0] seed = 32'h000054B6;
   int checks = 0;
   int n_mismatch = 0;
   always #5 clk_sys = ~clk_sys;
   // Wire level: flash wins where it drives, host model elsewhere
   assign pinLevel = (ioOe & ioOut) | (~ioOe & hostOut);
   serial_flash #(.PROG_CYCLES(600)) DUT (.clk_sys(clk_sys), .rst(rst), .sclkPin(sclkPin),
      .selectPinN(selectPinN), .ioIn(pinLevel), .ioOut(ioOut), .ioOe(ioOe),
      .protectRangeBits(protRange), .quadIoEnable(quadIoEnable), .busyFlag(busyFlag),
      .writeLatch(writeLatch));
   flash_host host (.clk_sys(clk_sys), .pinLevel(pinLevel), .sclkPin(sclkPin),
      .selectPinN(selectPinN), .hostOut(hostOut), .rxValid(rxValid), .rxByte(rxByte));
   // Refused frames must never turn a driver on
   always @(posedge clk_sys) if (ioOe !== 4'h0) seenOe <= 1'b1;
   // Monitor: each returned byte meets the oldest note
   always @(posedge clk_sys) begin
      if (rxValid === 1'b1) begin
         e = (expQ.size() > 0) ? expQ.pop_front() : ~rxByte;
         `CHK(rxByte, e)
      end
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   // Data sits at F8..FF then 00..0F of page zero
   function automatic int ix(input logic [7:0] a);
      return (int'(a) >= 248) ? int'(a) - 248 : int'(a) + 8;
   endfunction
   // wl: -1 refused, 0 linear, else wrap length
   task automatic rd(input logic [7:0] op, input int al, input int dz, input int dl,
      input logic [23:0] a, input logic [7:0] m, input int n, input int wl);
      logic [7:0] p;
      logic [7:0] mk;
      p = a[7:0];
      mk = 8'(wl - 1);
      host.frameOpen();
      if (op != 8'h00) host.xb(op, 1, 1, 0);
      for (int i = 2; i >= 0; i--) host.xb(a[8 * i +: 8], al, 1, 0);
      if (al > 1) host.xb(m, al, 1, 0);
      repeat (dz) host.xb(8'h00, al, 1, 0);
      for (int j = 0; j < n; j++) begin
         if (wl >= 0) expQ.push_back(dat[ix(p)]);
         host.xb(8'h00, dl, 0, wl >= 0);
         p = (wl > 0) ? ((p & ~mk) | (8'(p + 1) & mk)) : 8'(p + 1);
      end
      host.frameClose();
   endtask
   task automatic pg(input logic [7:0] op, input int dl, input logic [23:0] a, input int n,
      input logic [7:0] x);
      host.frameOpen();
      host.xb(`OP_LATCH_SET, 1, 1, 0);
      host.frameClose();
      `CHK(writeLatch, 1'b1)
      host.frameOpen();
      host.xb(op, 1, 1, 0);
      for (int i = 2; i >= 0; i--) host.xb(a[8 * i +: 8], 1, 1, 0);
      for (int j = 0; j < n; j++) host.xb(dat[j] ^ x, dl, 1, 0);
      host.frameClose();
   endtask
   task automatic ws(input logic [7:0] w);
      host.frameOpen();
      host.xb(`OP_WRAP_SET, 1, 1, 0);
      repeat (3) host.xb(8'h00, 1, 1, 0);
      host.xb(w, 1, 1, 0);
      host.frameClose();
   endtask
   task automatic waitIdle();
      for (int i = 0; i < 2000 && busyFlag !== 1'b0; i++) @(posedge clk_sys);
      `CHK(busyFlag, 1'b0)
   endtask
   task automatic give_verdict();
      $display("Counts: %0d checks, %0d mismatches", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Watchdog well beyond the expected run length
   initial begin
      #800000;
      n_mismatch++;
      give_verdict();
   end
   initial begin
      for (int i = 0; i < 24; i++) begin
         seed = xs(seed);
         dat[i] = seed[7:0];
      end
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (4) @(posedge clk_sys);
      pg(`OP_QUAD_PAGE, 4, 24'h0000F8, 24, 8'h00);
      `CHK(busyFlag, 1'b1)
      seenOe <= 1'b0;
      rd(`OP_READ, 1, 0, 1, 24'h000000, 8'h00, 1, -1);
      `CHK(seenOe, 1'b0)
      waitIdle();
      `CHK(writeLatch, 1'b0)
      expQ.push_back(8'h00);
      host.frameOpen();
      host.xb(`OP_STATUS, 1, 1, 0);
      host.xb(8'h00, 1, 0, 1);
      host.frameClose();
      protRange <= 5'h01;
      pg(`OP_PAGE_WRITE, 1, 24'h0FF0F8, 4, 8'hFF);
      waitIdle();
      protRange <= 5'h00;
      $display("Test program done");
      rd(`OP_READ, 1, 0, 1, 24'h000000, 8'h00, 3, 0);
      rd(`OP_READ, 1, 0, 1, 24'h0000F8, 8'h00, 2, 0);
      rd(`OP_FAST, 1, 1, 1, 24'h0000FE, 8'h00, 2, 0);
      rd(`OP_DUAL_OUT, 1, 1, 2, 24'h0000F9, 8'h00, 2, 0);
      rd(`OP_QUAD_OUT, 1, 1, 4, 24'h000004, 8'h00, 2, 0);
      rd(`OP_DUAL_IO, 2, 0, 2, 24'h0000FA, 8'h20, 2, 0);
      rd(8'h00, 2, 0, 2, 24'h000005, 8'h00, 2, 0);
      rd(`OP_QUAD_IO, 4, 2, 4, 24'h000006, 8'h20, 2, 0);
      rd(8'h00, 4, 2, 4, 24'h0000FC, 8'h00, 2, 0);
      $display("Test reads done");
      ws(8'h00);
      rd(`OP_QUAD_IO, 4, 2, 4, 24'h0000FE, 8'h00, 4, 8);
      rd(`OP_QUAD_IO, 4, 2, 4, 24'h000006, 8'h00, 3, 8);
      ws(8'h20);
      rd(`OP_QUAD_IO, 4, 2, 4, 24'h00000E, 8'h00, 3, 16);
      ws(8'h10);
      rd(`OP_QUAD_IO, 4, 2, 4, 24'h000006, 8'h00, 3, 0);
      $display("Test wrap done");
      quadIoEnable <= 1'b0;
      seenOe <= 1'b0;
      rd(`OP_QUAD_OUT, 1, 1, 4, 24'h000000, 8'h00, 1, -1);
      `CHK(seenOe, 1'b0)
      $display("Test refusal done");
      give_verdict();
   end
endmodule
